// ==== design/alm_defines.svh ====
// Holds the offsets, field positions, reset values and timing counts of the level monitor.
// Assumes inclusion by bare name from the level monitor module, its checker and the testbench.
`ifndef ALM_DEFINES_SVH
`define ALM_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ALM_OFF_PIN_FUNC      12'h040
`define ALM_OFF_UPPER_LO      12'h247
`define ALM_OFF_UPPER_HI      12'h248
`define ALM_OFF_LOWER_LO      12'h249
`define ALM_OFF_LOWER_HI      12'h24A
`define ALM_OFF_DWELL_LO      12'h24B
`define ALM_OFF_DWELL_HI      12'h24C
`define ALM_OFF_MON_CTRL      12'h270
`define ALM_OFF_PERIOD_0      12'h271
`define ALM_OFF_PERIOD_1      12'h272
`define ALM_OFF_PERIOD_2      12'h273
`define ALM_OFF_PEAK_A_LO     12'h274
`define ALM_OFF_PEAK_A_HI     12'h275
`define ALM_OFF_PEAK_B_LO     12'h276
`define ALM_OFF_PEAK_B_HI     12'h277
`define ALM_OFF_FD_CTRL       12'h559
`define ALM_OFF_OVR_CLEAR     12'h562
`define ALM_OFF_OVR_STICKY    12'h563

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define ALM_FD_EN_BIT         0
`define ALM_MON_PEAK_EN_BIT   1
`define ALM_PIN_SEL_DIODE     3'h1
`define ALM_REG_RESET         8'h00
`define ALM_HI5_MASK          8'h1F

// ****************************************************************
// Timing counts
// ****************************************************************
`define ALM_SAMPLE_LATENCY    4
`define ALM_DECIM_DIV         16'h0001
`define ALM_UPPER_LATENCY_MAX 28

`endif

// ==== design/alm_level_monitor.sv ====
// Holds the level monitor: fast threshold detect, overrange indicator and sticky bits, peak monitor.
// Assumes one converter sample per clock on each channel and a decoded register port from the serial host.
`include "alm_defines.svh"

module alm_level_monitor (
	input  wire logic        clk_sys_in,
	input  wire logic        resetn_in,
	input  wire logic [13:0] sample_a_in,
	input  wire logic [13:0] sample_b_in,
	input  wire logic        overrange_raw_in,
	input  wire logic [3:0]  vc_overrange_in,
	input  wire logic        temp_diode_in,
	input  wire logic [11:0] reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [7:0]  reg_wdata_in,
	output logic      [7:0]  reg_rdata_out,
	output logic             threshold_flag_out_a,
	output logic             threshold_flag_out_b,
	output logic             overrange_out
);

	// ****************************************************************
	// Magnitude
	// ****************************************************************
	// absolute value
	// Full negative scale would wrap to zero if simply cut, so it saturates instead.
	function automatic alm_pkg::alm_mag_t alm_mag(input logic [13:0] s);
		logic [13:0] a;
		a = s[13] ? (~s + 14'h0001) : s;
		alm_mag = a[13] ? 13'h1FFF : a[12:0];
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0]  pin_func_reg;
	logic [7:0]  upper_lo_reg;
	logic [7:0]  upper_hi_reg;
	logic [7:0]  lower_lo_reg;
	logic [7:0]  lower_hi_reg;
	logic [7:0]  dwell_lo_reg;
	logic [7:0]  dwell_hi_reg;
	logic [7:0]  mon_ctrl_reg;
	logic [23:0] period_reg;
	logic [7:0]  fd_ctrl_reg;
	logic [7:0]  ovr_clear_reg;
	logic [3:0]  ovr_sticky_reg;
	logic [3:0]  ovr_sticky_next;
	logic [7:0]  rdata_next;

	wire logic   wr_pin   = reg_wr_in && (reg_addr_in == `ALM_OFF_PIN_FUNC);
	wire logic   wr_uplo  = reg_wr_in && (reg_addr_in == `ALM_OFF_UPPER_LO);
	wire logic   wr_uphi  = reg_wr_in && (reg_addr_in == `ALM_OFF_UPPER_HI);
	wire logic   wr_lolo  = reg_wr_in && (reg_addr_in == `ALM_OFF_LOWER_LO);
	wire logic   wr_lohi  = reg_wr_in && (reg_addr_in == `ALM_OFF_LOWER_HI);
	wire logic   wr_dwlo  = reg_wr_in && (reg_addr_in == `ALM_OFF_DWELL_LO);
	wire logic   wr_dwhi  = reg_wr_in && (reg_addr_in == `ALM_OFF_DWELL_HI);
	wire logic   wr_mon   = reg_wr_in && (reg_addr_in == `ALM_OFF_MON_CTRL);
	wire logic   wr_per0  = reg_wr_in && (reg_addr_in == `ALM_OFF_PERIOD_0);
	wire logic   wr_per1  = reg_wr_in && (reg_addr_in == `ALM_OFF_PERIOD_1);
	wire logic   wr_per2  = reg_wr_in && (reg_addr_in == `ALM_OFF_PERIOD_2);
	wire logic   wr_fd    = reg_wr_in && (reg_addr_in == `ALM_OFF_FD_CTRL);
	wire logic   wr_clr   = reg_wr_in && (reg_addr_in == `ALM_OFF_OVR_CLEAR);

	wire alm_pkg::alm_mag_t upper_thr = {upper_hi_reg[4:0], upper_lo_reg};
	wire alm_pkg::alm_mag_t lower_thr = {lower_hi_reg[4:0], lower_lo_reg};
	wire logic [15:0]       dwell     = {dwell_hi_reg, dwell_lo_reg};
	wire logic              fd_en     = fd_ctrl_reg[`ALM_FD_EN_BIT];
	wire logic              peak_en   = mon_ctrl_reg[`ALM_MON_PEAK_EN_BIT];

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pin_func_reg  <= `ALM_REG_RESET;
			upper_lo_reg  <= `ALM_REG_RESET;
			upper_hi_reg  <= `ALM_REG_RESET;
			lower_lo_reg  <= `ALM_REG_RESET;
			lower_hi_reg  <= `ALM_REG_RESET;
			dwell_lo_reg  <= `ALM_REG_RESET;
			dwell_hi_reg  <= `ALM_REG_RESET;
			mon_ctrl_reg  <= `ALM_REG_RESET;
			period_reg    <= 24'h000000;
			fd_ctrl_reg   <= `ALM_REG_RESET;
			ovr_clear_reg <= `ALM_REG_RESET;
		end else begin
			if (wr_pin)  pin_func_reg  <= reg_wdata_in;
			if (wr_uplo) upper_lo_reg  <= reg_wdata_in;
			if (wr_uphi) upper_hi_reg  <= reg_wdata_in & `ALM_HI5_MASK;
			if (wr_lolo) lower_lo_reg  <= reg_wdata_in;
			if (wr_lohi) lower_hi_reg  <= reg_wdata_in & `ALM_HI5_MASK;
			if (wr_dwlo) dwell_lo_reg  <= reg_wdata_in;
			if (wr_dwhi) dwell_hi_reg  <= reg_wdata_in;
			if (wr_mon)  mon_ctrl_reg  <= reg_wdata_in;
			if (wr_per0) period_reg[7:0]   <= reg_wdata_in;
			if (wr_per1) period_reg[15:8]  <= reg_wdata_in;
			if (wr_per2) period_reg[23:16] <= reg_wdata_in;
			if (wr_fd)   fd_ctrl_reg   <= reg_wdata_in;
			if (wr_clr)  ovr_clear_reg <= reg_wdata_in;
		end
	end

	// ****************************************************************
	// Overrange
	// ****************************************************************
	// sticky set wins over clear
	// clear acts while the clear bit is held set
	assign ovr_sticky_next = vc_overrange_in | (ovr_sticky_reg & ~ovr_clear_reg[3:0]);

	logic [`ALM_SAMPLE_LATENCY-1:0] ovr_pipe_reg;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ovr_sticky_reg <= 4'h0;
			ovr_pipe_reg   <= '0;
		end else begin
			ovr_sticky_reg <= ovr_sticky_next;
			ovr_pipe_reg   <= {ovr_pipe_reg[`ALM_SAMPLE_LATENCY-2:0], overrange_raw_in};
		end
	end

	assign overrange_out = ovr_pipe_reg[`ALM_SAMPLE_LATENCY-1];

	// ****************************************************************
	// Decimated clock enable and monitor period timer
	// ****************************************************************
	logic [15:0]             decim_cnt_reg;
	logic [23:0]             timer_reg;
	logic                    seed_reg;
	logic                    peak_en_d_reg;
	alm_pkg::alm_mon_state_t mon_state_reg;
	alm_pkg::alm_mon_state_t mon_state_next;

	wire logic decim_en  = (decim_cnt_reg >= (`ALM_DECIM_DIV - 16'h0001));
	wire logic start     = peak_en && !peak_en_d_reg;
	wire logic timer_hit = decim_en && (timer_reg <= 24'h000001);

	always_comb begin
		case (mon_state_reg)
			alm_pkg::ALM_MON_IDLE: mon_state_next = start ? alm_pkg::ALM_MON_RUN : alm_pkg::ALM_MON_IDLE;
			alm_pkg::ALM_MON_RUN:  mon_state_next = peak_en ? alm_pkg::ALM_MON_RUN : alm_pkg::ALM_MON_IDLE;
			default:               mon_state_next = alm_pkg::ALM_MON_IDLE;
		endcase
	end

	wire logic running = (mon_state_reg == alm_pkg::ALM_MON_RUN);

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			decim_cnt_reg <= 16'h0000;
			timer_reg     <= 24'h000000;
			seed_reg      <= 1'b1;
			peak_en_d_reg <= 1'b0;
			mon_state_reg <= alm_pkg::ALM_MON_IDLE;
		end else begin
			decim_cnt_reg <= decim_en ? 16'h0000 : decim_cnt_reg + 16'h0001;
			peak_en_d_reg <= peak_en;
			mon_state_reg <= mon_state_next;
			// load on enable, then count down at the decimated rate
			if (start) begin
				timer_reg <= period_reg;
				seed_reg  <= 1'b1;
			end else if (running && decim_en) begin
				// reload and reseed at count 1, or at count 0 when the period is 0
				if (timer_hit) begin
					timer_reg <= period_reg;
					seed_reg  <= 1'b1;
				end else begin
					timer_reg <= timer_reg - 24'h000001;
					seed_reg  <= 1'b0;
				end
			end
		end
	end

	// ****************************************************************
	// Per-channel fast detect and peak detect
	// ****************************************************************
	// one detector per channel
	wire logic [13:0] sample_w [2];
	assign sample_w[0] = sample_a_in;
	assign sample_w[1] = sample_b_in;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : ch
			wire alm_pkg::alm_mag_t mag     = alm_mag(sample_w[gi]);
			wire logic              above   = (mag > upper_thr);
			wire logic              below   = (mag < lower_thr);
			logic [16:0]            dwell_cnt_reg;
			logic                   flag_reg;
			alm_pkg::alm_mag_t      store_reg;
			alm_pkg::alm_mag_t      hold_reg;
			wire logic              dwell_done = (dwell_cnt_reg > {1'b0, dwell});

			always_ff @(posedge clk_sys_in or negedge resetn_in) begin
				if (!resetn_in) begin
					dwell_cnt_reg <= 17'h00000;
					flag_reg      <= 1'b0;
				end else if (!fd_en) begin
					dwell_cnt_reg <= 17'h00000;
					flag_reg      <= 1'b0;
				end else begin
					// count consecutive samples below the lower level
					if (!below)
						dwell_cnt_reg <= 17'h00000;
					else if (!dwell_done)
						dwell_cnt_reg <= dwell_cnt_reg + 17'h00001;
					// set at once above upper level
					if (above)
						flag_reg <= 1'b1;
					else if (below && dwell_done)
						flag_reg <= 1'b0;
				end
			end

			always_ff @(posedge clk_sys_in or negedge resetn_in) begin
				if (!resetn_in) begin
					store_reg <= 13'h0000;
					hold_reg  <= 13'h0000;
				end else if (running && decim_en) begin
					// seed, then keep the larger magnitude
					store_reg <= (seed_reg || mag > store_reg) ? mag : store_reg;
					if (timer_hit)
						hold_reg <= (seed_reg || mag > store_reg) ? mag : store_reg;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Flag pins
	// ****************************************************************
	// flag pin lags the sample by two clocks, well inside the bound
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			threshold_flag_out_a <= 1'b0;
			threshold_flag_out_b <= 1'b0;
		end else begin
			// diode routing on channel A pin
			threshold_flag_out_a <= (pin_func_reg[2:0] == `ALM_PIN_SEL_DIODE) ? temp_diode_in : ch[0].flag_reg;
			threshold_flag_out_b <= ch[1].flag_reg;
		end
	end

	// ****************************************************************
	// Read back
	// ****************************************************************
	// register readback
	// 13-bit peaks and 24-bit period readable
	always_comb begin
		case (reg_addr_in)
			`ALM_OFF_PIN_FUNC:   rdata_next = pin_func_reg;
			`ALM_OFF_UPPER_LO:   rdata_next = upper_lo_reg;
			`ALM_OFF_UPPER_HI:   rdata_next = upper_hi_reg;
			`ALM_OFF_LOWER_LO:   rdata_next = lower_lo_reg;
			`ALM_OFF_LOWER_HI:   rdata_next = lower_hi_reg;
			`ALM_OFF_DWELL_LO:   rdata_next = dwell_lo_reg;
			`ALM_OFF_DWELL_HI:   rdata_next = dwell_hi_reg;
			`ALM_OFF_MON_CTRL:   rdata_next = mon_ctrl_reg;
			`ALM_OFF_PERIOD_0:   rdata_next = period_reg[7:0];
			`ALM_OFF_PERIOD_1:   rdata_next = period_reg[15:8];
			`ALM_OFF_PERIOD_2:   rdata_next = period_reg[23:16];
			`ALM_OFF_PEAK_A_LO:  rdata_next = ch[0].hold_reg[7:0];
			`ALM_OFF_PEAK_A_HI:  rdata_next = {3'h0, ch[0].hold_reg[12:8]};
			`ALM_OFF_PEAK_B_LO:  rdata_next = ch[1].hold_reg[7:0];
			`ALM_OFF_PEAK_B_HI:  rdata_next = {3'h0, ch[1].hold_reg[12:8]};
			`ALM_OFF_FD_CTRL:    rdata_next = fd_ctrl_reg;
			`ALM_OFF_OVR_CLEAR:  rdata_next = ovr_clear_reg;
			`ALM_OFF_OVR_STICKY: rdata_next = {4'h0, ovr_sticky_reg};
			default:             rdata_next = 8'h00;
		endcase
	end

	// Data is held between reads so a slow serial host can shift it out at leisure.
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
			reg_rdata_out <= rdata_next;
	end

endmodule // alm_level_monitor

// ==== design/alm_pkg.sv ====
// Holds the types shared by the level monitor.
// Assumes the defines header is compiled alongside.
package alm_pkg;

	typedef logic [12:0] alm_mag_t;

	typedef enum logic [1:0] {
		ALM_MON_IDLE = 2'b01,
		ALM_MON_RUN  = 2'b10
	} alm_mon_state_t;

endpackage : alm_pkg

// ==== verif/alm_agc_model.sv ====
// Holds a gain control model that counts rises of each fast detect pin.
// Assumes the pins are registered on the same clock.
module alm_agc_model (
	input  wire logic       clk_sys_in,
	input  wire logic       resetn_in,
	input  wire logic       flag_a_in,
	input  wire logic       flag_b_in,
	output logic      [7:0] rise_a_out,
	output logic      [7:0] rise_b_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_a_reg;
	logic last_b_reg;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			last_a_reg <= 1'b0;
			last_b_reg <= 1'b0;
			rise_a_out <= 8'h00;
			rise_b_out <= 8'h00;
		end else begin
			last_a_reg <= flag_a_in;
			last_b_reg <= flag_b_in;
			rise_a_out <= rise_a_out + 8'(flag_a_in && !last_a_reg);
			rise_b_out <= rise_b_out + 8'(flag_b_in && !last_b_reg);
		end
	end
endmodule // alm_agc_model

// ==== verif/alm_level_monitor_checker.sv ====
// Holds the port checks of the level monitor.
// Assumes it is bound to alm_level_monitor and sees one clock domain.
`include "alm_defines.svh"
module alm_level_monitor_checker (
	input wire logic        clk_sys_in,
	input wire logic        resetn_in,
	input wire logic [13:0] sample_a_in,
	input wire logic [13:0] sample_b_in,
	input wire logic        overrange_raw_in,
	input wire logic [3:0]  vc_overrange_in,
	input wire logic        temp_diode_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [7:0]  reg_wdata_in,
	input wire logic [7:0]  reg_rdata_out,
	input wire logic        threshold_flag_out_a,
	input wire logic        threshold_flag_out_b,
	input wire logic        overrange_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        fd_en_reg;
	logic [12:0] upper_reg;
	logic [12:0] lower_reg;
	logic [2:0]  up_cnt_reg;
	logic [15:0] dwell_reg;
	logic [16:0] run_reg;
	logic [12:0] mag_b;
	logic        below_b;
	assign mag_b = !sample_b_in[13] ? sample_b_in[12:0] : (sample_b_in == 14'h2000) ? 13'h1FFF : 13'(-sample_b_in);
	assign below_b = mag_b < lower_reg;
	// ****
	// Shadow of the registers the checks depend on.
	// ****
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			fd_en_reg  <= 1'b0;
			upper_reg  <= 13'h0000;
			lower_reg  <= 13'h0000;
			up_cnt_reg <= 3'h0;
			dwell_reg  <= 16'h0000;
			run_reg    <= 17'h00000;
		end else begin
			if (up_cnt_reg != 3'h4) begin
				up_cnt_reg <= up_cnt_reg + 3'h1;
			end
			// Run of consecutive low samples on channel B, saturating so it never wraps back to zero.
			if (!below_b) begin
				run_reg <= 17'h00000;
			end else if (run_reg != 17'h1FFFF) begin
				run_reg <= run_reg + 17'h00001;
			end
			if (reg_wr_in) begin
				case (reg_addr_in)
					`ALM_OFF_FD_CTRL: fd_en_reg <= reg_wdata_in[0];
					`ALM_OFF_UPPER_LO: upper_reg[7:0] <= reg_wdata_in;
					`ALM_OFF_UPPER_HI: upper_reg[12:8] <= reg_wdata_in[4:0];
					`ALM_OFF_LOWER_LO: lower_reg[7:0] <= reg_wdata_in;
					`ALM_OFF_LOWER_HI: lower_reg[12:8] <= reg_wdata_in[4:0];
					`ALM_OFF_DWELL_LO: dwell_reg[7:0] <= reg_wdata_in;
					`ALM_OFF_DWELL_HI: dwell_reg[15:8] <= reg_wdata_in;
					default: ;
				endcase
			end
		end
	end
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	sequence s_fd_off;
		!fd_en_reg [*2];
	endsequence
	sequence s_sticky_rd;
		reg_rd_in && reg_addr_in == `ALM_OFF_OVR_STICKY;
	endsequence
	ovr_delay_a: assert property (up_cnt_reg == 3'h4 |-> overrange_out == $past(overrange_raw_in, 4))
		else $error("overrange output not four clocks behind its input");
	rd_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data changed without a read");
	unmapped_rd_a: assert property (reg_rd_in && reg_addr_in == 12'h100 |=> reg_rdata_out == 8'h00)
		else $error("unmapped read returned nonzero data");
	fd_rise_a: assert property (fd_en_reg && mag_b > upper_reg |-> ##2 threshold_flag_out_b)
		else $error("channel B flag did not rise two clocks after crossing");
	// The pin falls two clocks after the release decision, so the settings are taken from then and the run one clock later, with the deciding sample counted.
	fd_fall_a: assert property ($fell(threshold_flag_out_b) |-> !$past(fd_en_reg, 2) || $past(run_reg) >= {1'b0, $past(dwell_reg, 2)} + 17'h00002)
		else $error("channel B flag fell without enough low samples");
	fd_off_a: assert property (s_fd_off |=> !threshold_flag_out_b)
		else $error("channel B flag high while detection disabled");
	sticky_rd_a: assert property ((up_cnt_reg != 3'h0) and s_sticky_rd |=> (reg_rdata_out[3:0] & $past(vc_overrange_in, 2)) == $past(vc_overrange_in, 2))
		else $error("sticky status missed an overrange event");
	sticky_hi_a: assert property (s_sticky_rd |=> reg_rdata_out[7:4] == 4'h0)
		else $error("sticky status upper bits not zero");
endmodule // alm_level_monitor_checker

bind alm_level_monitor alm_level_monitor_checker alm_level_monitor_checker_i (
	.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .sample_a_in(sample_a_in), .sample_b_in(sample_b_in),
	.overrange_raw_in(overrange_raw_in), .vc_overrange_in(vc_overrange_in), .temp_diode_in(temp_diode_in),
	.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
	.reg_rdata_out(reg_rdata_out), .threshold_flag_out_a(threshold_flag_out_a),
	.threshold_flag_out_b(threshold_flag_out_b), .overrange_out(overrange_out));

// ==== verif/testbench.sv ====
// Holds the self-checking bench of the level monitor.
// Assumes the checker binds itself and the gain control model is compiled.
`include "alm_defines.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic [13:0] sample_a_in = 14'h0000;
	logic [13:0] sample_b_in = 14'h0000;
	logic        overrange_raw_in = 1'b0;
	logic [3:0]  vc_overrange_in = 4'h0;
	logic        temp_diode_in = 1'b0;
	logic [11:0] reg_addr_in = 12'h000;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [7:0]  reg_wdata_in = 8'h00;
	logic [7:0]  reg_rdata_out;
	logic        threshold_flag_out_a;
	logic        threshold_flag_out_b;
	logic        overrange_out;
	logic [7:0]  rise_a;
	logic [7:0]  rise_b;
	logic        rd_pend = 1'b0;
	logic [7:0]  exp_q[$];
	logic [7:0]  rnd;
	logic [11:0] offs[12] = '{12'h040, 12'h247, 12'h248, 12'h249, 12'h24A, 12'h24B, 12'h24C, 12'h270,
		12'h559, 12'h562, 12'h563, 12'h100};
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cyc = 0;

	alm_level_monitor alm_level_monitor_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.sample_a_in(sample_a_in), .sample_b_in(sample_b_in), .overrange_raw_in(overrange_raw_in),
		.vc_overrange_in(vc_overrange_in), .temp_diode_in(temp_diode_in), .reg_addr_in(reg_addr_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.threshold_flag_out_a(threshold_flag_out_a), .threshold_flag_out_b(threshold_flag_out_b),
		.overrange_out(overrange_out));
	alm_agc_model alm_agc_model_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.flag_a_in(threshold_flag_out_a), .flag_b_in(threshold_flag_out_b), .rise_a_out(rise_a), .rise_b_out(rise_b));

	initial begin
		forever #25 clk_sys_in = ~clk_sys_in;
	end

	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
		comparisons++;
		if (got !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, e, got);
		end
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d, errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	endtask

	// The expected value is queued before the strobe; the monitor pops it when data appears.
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
	endtask

	task automatic sb(input logic [13:0] v);
		@(posedge clk_sys_in);
		sample_b_in <= v;
		sample_a_in <= 14'($urandom_range(39));
	endtask

	task automatic pk(input logic [13:0] a, input logic [13:0] b, input logic [12:0] ea, input logic [12:0] eb);
		@(posedge clk_sys_in);
		sample_a_in <= a;
		sample_b_in <= b;
		repeat (12) @(posedge clk_sys_in);
		rd(`ALM_OFF_PEAK_A_LO, ea[7:0]);
		rd(`ALM_OFF_PEAK_A_HI, {3'h0, ea[12:8]});
		rd(`ALM_OFF_PEAK_B_LO, eb[7:0]);
		rd(`ALM_OFF_PEAK_B_HI, {3'h0, eb[12:8]});
	endtask

	always @(posedge clk_sys_in) begin
		cyc++;
		overrange_raw_in <= 1'($urandom);
		if (rd_pend) begin
			chk("read data", exp_q.pop_front(), reg_rdata_out);
		end
		rd_pend <= reg_rd_in;
		if (cyc == 5000) begin
			error_cnt++;
			give_verdict();
		end
	end

	initial begin
		void'($urandom(32'hBEC00AC7));
		repeat (8) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		foreach (offs[i]) rd(offs[i], 8'h00);
		for (int i = 0; i < 12; i++) begin
			rnd = 8'($urandom);
			wr(offs[i], rnd);
			rd(offs[i], i > 9 ? 8'h00 : (i == 2 || i == 4) ? rnd & `ALM_HI5_MASK : rnd);
		end
		for (int i = 0; i < 10; i++) wr(offs[i], 8'h00);
		wr(`ALM_OFF_UPPER_LO, 8'h64);
		wr(`ALM_OFF_LOWER_LO, 8'h32);
		wr(`ALM_OFF_DWELL_LO, 8'h03);
		wr(`ALM_OFF_FD_CTRL, 8'h01);
		sb(14'h3F38);
		sb(14'h0028);
		#1 chk("flag b early", 8'h00, {7'h00, threshold_flag_out_b});
		sb(14'h0028);
		#1 chk("flag b set", 8'h01, {7'h00, threshold_flag_out_b});
		sb(14'h0032);
		for (int j = 1; j <= 7; j++) begin
			sb(14'h0028);
			#1 chk("flag b dwell", {7'h00, j < 7}, {7'h00, threshold_flag_out_b});
		end
		chk("flag a", 8'h00, {7'h00, threshold_flag_out_a});
		chk("gain model rises", 8'h01, rise_b);
		chk("gain model rises a", 8'h00, rise_a);
		wr(`ALM_OFF_FD_CTRL, 8'h00);
		temp_diode_in <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			wr(`ALM_OFF_PIN_FUNC, 8'(c));
			repeat (3) @(posedge clk_sys_in);
			#1 chk("pin a source", {7'h00, c == 1}, {7'h00, threshold_flag_out_a});
		end
		wr(`ALM_OFF_PIN_FUNC, 8'h00);
		@(posedge clk_sys_in);
		vc_overrange_in <= 4'h5;
		@(posedge clk_sys_in);
		vc_overrange_in <= 4'h0;
		rd(`ALM_OFF_OVR_STICKY, 8'h05);
		wr(`ALM_OFF_OVR_CLEAR, 8'h01);
		wr(`ALM_OFF_OVR_CLEAR, 8'h00);
		rd(`ALM_OFF_OVR_STICKY, 8'h04);
		wr(`ALM_OFF_PERIOD_0, 8'h03);
		wr(`ALM_OFF_MON_CTRL, 8'h02);
		pk(14'h2DCC, 14'h2000, 13'h1234, 13'h1FFF);
		pk(14'h0456, 14'h3FDF, 13'h0456, 13'h0021);
		repeat (3) @(posedge clk_sys_in);
		give_verdict();
	end
endmodule // testbench
